// [dv/pbwf_checker.sv]
// Checker: handshake and forwarding rules at the top ports
// Assumes a bind onto pbwf_top; one clock domain
`timescale 1ns/1ps
`include "pbwf_defs.svh"
module pbwf_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic frame_n,
  input wire logic [3:0] cbe_n,
  input wire logic devsel_n,
  input wire logic trdy_n,
  input wire logic stop_n,
  input wire logic tgt_oe_n,
  input wire logic tgt_req,
  input wire logic [3:0] tgt_cmd,
  input wire logic [31:0] tgt_addr,
  input wire logic [31:0] tgt_data,
  input wire logic tgt_done,
  input wire logic serr_en,
  input wire logic pw_valid,
  input wire logic [36:0] pw_data,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic primary_system_error_out
);
  logic dly_q;
  logic [1:0] wi_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Class latched at the address edge
  always_ff @(posedge clk)
    if (!rst_n)
      dly_q <= 1'b0;
    else if ($fell(frame_n))
      dly_q <= (~cbe_n == `PBWF_CMD_IOWR) || (~cbe_n == `PBWF_CMD_CFGWR);
  always_ff @(posedge clk)
    if (!rst_n)
      wi_q <= 2'h0;
    else if (cfg_wr && cfg_addr == `PBWF_OFS_WI_CTRL)
      wi_q <= cfg_wdata[`PBWF_WI_HI:`PBWF_WI_LO];
  ////////////////////////////////////////
  chk_devsel_medium: assert property (
    $fell(devsel_n) |-> $past(frame_n, 3) && !$past(frame_n, 2))
    else $error("devsel timing");
  chk_posted_trdy: assert property (
    $fell(devsel_n) && stop_n && !dly_q |=> !trdy_n)
    else $error("posted trdy late");
  chk_delayed_nowait: assert property (
    $fell(devsel_n) && dly_q |-> trdy_n)
    else $error("delayed data at claim");
  chk_delayed_single: assert property (
    !trdy_n && dly_q && !frame_n |-> !stop_n)
    else $error("delayed not stopped");
  chk_oe_drive: assert property (
    !devsel_n || !trdy_n || !stop_n |-> !tgt_oe_n)
    else $error("outputs undriven");
  chk_release_turn: assert property (
    $rose(devsel_n) |-> trdy_n && stop_n && !tgt_oe_n ##1 tgt_oe_n)
    else $error("release order");
  chk_req_hold: assert property (
    tgt_req && $past(tgt_req) |->
      $stable(tgt_addr) && $stable(tgt_data) && $stable(tgt_cmd))
    else $error("request fields moved");
  chk_done_drop: assert property (
    tgt_done |=> !tgt_req)
    else $error("request after done");
  chk_err_pulse: assert property (
    primary_system_error_out |-> serr_en ##1 !primary_system_error_out)
    else $error("error not gated pulse");
  chk_mwi_as_mw: assert property (
    pw_valid && pw_data[36] && wi_q == 2'h0 |->
      pw_data[35:32] != `PBWF_CMD_MWI)
    else $error("invalidate not converted");
  cov_retry: cover property ($fell(devsel_n) && !stop_n);
  cov_done: cover property (tgt_done);
  cov_serr: cover property (primary_system_error_out);
endmodule : pbwf_checker

// [dv/pbwf_tgt_model.sv]
// Target-bus master model answering forwarded delayed writes
// Assumes tgt_req is a level; answers pulse only while it holds
`timescale 1ns/1ps
module pbwf_tgt_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tgt_req,
  input wire logic [3:0] lat,
  input wire logic [7:0] n_retry,
  input wire logic never,
  output logic tgt_done,
  output logic tgt_retry,
  output logic tgt_err,
  output logic [7:0] tries
);
  logic [3:0] cnt_q;
  logic [7:0] per_q;
  // Error answers not modelled
  assign tgt_err = 1'b0;
  always_ff @(posedge clk)
    if (!rst_n || !tgt_req || tgt_done || tgt_retry)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_q + 4'h1;
  always_ff @(posedge clk)
    if (!rst_n || !tgt_req || tgt_done)
      per_q <= 8'h0;
    else if (tgt_retry)
      per_q <= per_q + 8'h1;
  always_ff @(posedge clk)
    if (!rst_n)
      tries <= 8'h0;
    else if (tgt_retry)
      tries <= tries + 8'h1;
  // Lat slows answers; never exhausts the limit
  always_ff @(posedge clk)
    if (!rst_n || !tgt_req || tgt_done || tgt_retry || cnt_q != lat)
    begin
      tgt_done <= 1'b0;
      tgt_retry <= 1'b0;
    end
    else
    begin
      tgt_retry <= never || per_q < n_retry;
      tgt_done <= !never && per_q >= n_retry;
    end
endmodule : pbwf_tgt_model

// [dv/pbwf_top_tb.sv]
// Bench: initiator tasks and register port on the write core
// Assumes checker and target model compiled alongside
`timescale 1ns/1ps
`include "pbwf_defs.svh"
module pbwf_top_tb;
  localparam logic [31:0] RST_RETRY = 32'h40;
  logic clk = 1'b0, rst_n = 1'b0, frame_n = 1'b1, irdy_n = 1'b1;
  logic par = 1'b0, decode_hit = 1'b0, upstream = 1'b0, serr_en = 1'b1;
  logic fbb_up_en = 1'b0, fbb_dn_en = 1'b0, posted_clear = 1'b1;
  logic pw_ready = 1'b1, cfg_wr = 1'b0, never = 1'b0, req_d = 1'b0;
  logic [31:0] ad = 32'h0, cfg_wdata = 32'h0;
  logic [3:0] cbe_n = 4'hf, lat = 4'h0;
  logic [7:0] cls = 8'h04, cfg_addr = 8'h0, n_retry = 8'h0;
  logic devsel_n, trdy_n, stop_n, tgt_oe_n, tgt_req, tgt_done, tgt_retry;
  logic tgt_err, pw_valid, primary_system_error_out;
  logic [3:0] tgt_cmd, tgt_be_n;
  logic [31:0] tgt_addr, tgt_data, cfg_rdata;
  logic [36:0] pw_data;
  logic [7:0] tries;
  logic [36:0] pw_q[$];
  int error_cnt = 0, n_compared = 0, serr_cnt = 0, issue_cnt = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    if (pw_valid && pw_ready) pw_q.push_back(pw_data);
    if (primary_system_error_out) serr_cnt++;
    if (tgt_req && !req_d) issue_cnt++;
    req_d <= tgt_req;
  end
  pbwf_top #(.RETRY_RESET(RST_RETRY)) i_dut (.clk(clk), .rst_n(rst_n),
    .frame_n(frame_n), .irdy_n(irdy_n), .ad(ad), .cbe_n(cbe_n), .par(par),
    .decode_hit(decode_hit), .upstream(upstream), .cls(cls),
    .serr_en(serr_en), .fbb_up_en(fbb_up_en), .fbb_dn_en(fbb_dn_en),
    .posted_clear(posted_clear), .devsel_n(devsel_n), .trdy_n(trdy_n),
    .stop_n(stop_n), .tgt_oe_n(tgt_oe_n), .tgt_req(tgt_req),
    .tgt_cmd(tgt_cmd), .tgt_addr(tgt_addr), .tgt_data(tgt_data),
    .tgt_be_n(tgt_be_n), .tgt_par(), .tgt_done(tgt_done),
    .tgt_retry(tgt_retry), .tgt_err(tgt_err), .pw_valid(pw_valid),
    .pw_ready(pw_ready), .pw_data(pw_data), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .primary_system_error_out(primary_system_error_out));
  pbwf_tgt_model i_tgt (.clk(clk), .rst_n(rst_n), .tgt_req(tgt_req),
    .lat(lat), .n_retry(n_retry), .never(never), .tgt_done(tgt_done),
    .tgt_retry(tgt_retry), .tgt_err(tgt_err), .tries(tries));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [36:0] seen,
      input logic [36:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cfg(input logic [7:0] a, input logic [31:0] d,
      input logic w);
    @(posedge clk);
    cfg_wr <= w;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    @(negedge clk);
  endtask : cfg
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    cfg(a, 32'h0, 1'b0);
    chk("cfg_rdata", cfg_rdata, exp);
  endtask : rd
  // Judge at the falling edge, act at the next rising edge
  task automatic pwr(input logic [3:0] cmd, input logic [31:0] a,
      input int n, input logic [3:0] be, input logic [31:0] d,
      output int nx);
    int t;
    nx = 0;
    @(posedge clk);
    frame_n <= 1'b0;
    ad <= a;
    cbe_n <= ~cmd;
    decode_hit <= 1'b1;
    @(posedge clk);
    frame_n <= n == 1;
    irdy_n <= 1'b0;
    ad <= d;
    cbe_n <= be;
    decode_hit <= 1'b0;
    par <= ^{a, ~cmd};
    for (t = 0; t < 40; t++)
    begin
      @(negedge clk);
      if (!trdy_n) nx++;
      if (!stop_n || (!trdy_n && nx == n)) break;
      @(posedge clk);
      ad <= d + 32'(nx);
      frame_n <= nx == n - 1;
    end
    chk("bus_end", t < 40, 1'b1);
    @(posedge clk);
    frame_n <= 1'b1;
    irdy_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : pwr
  ////////////////////////////////////////
  task automatic t_regs();
    rd(`PBWF_OFS_CHIP_CTRL, `PBWF_CC_RESET);
    rd(`PBWF_OFS_WI_CTRL, `PBWF_WI_RESET);
    rd(`PBWF_OFS_RETRY_CNT, RST_RETRY);
    cfg(`PBWF_OFS_RETRY_CNT, 32'h8, 1'b1);
    rd(`PBWF_OFS_RETRY_CNT, 32'h8);
    rd(8'h50, 32'h0);
  endtask : t_regs
  task automatic post_case(input logic [31:0] cc, input logic [31:0] wi,
      input logic [3:0] cmd, input logic [31:0] a, input int n,
      input int ex, input logic [3:0] oc);
    int nx;
    cfg(`PBWF_OFS_CHIP_CTRL, cc, 1'b1);
    cfg(`PBWF_OFS_WI_CTRL, wi, 1'b1);
    pw_q.delete();
    pwr(cmd, a, n, 4'h0, 32'h5a00_0000, nx);
    repeat (8) @(posedge clk);
    chk("xfers", nx, ex);
    chk("pw_count", pw_q.size(), ex + 1);
    chk("pw_addr", pw_q[0], {1'b1, oc, a});
    for (int i = 1; i < pw_q.size(); i++)
      chk("pw_data", pw_q[i], {5'h0, 32'h5a00_0000 + 32'(i - 1)});
  endtask : post_case
  task automatic t_posted();
    post_case(0, 0, `PBWF_CMD_MW, 32'hff8, 4, 2, `PBWF_CMD_MW);
    post_case(2, 0, `PBWF_CMD_MW, 32'h108, 4, 2, `PBWF_CMD_MW);
    post_case(0, 32'h180, `PBWF_CMD_MWI, 32'h104, 8, 3, `PBWF_CMD_MWI);
    post_case(0, 32'h080, `PBWF_CMD_MWI, 32'h104, 8, 8, `PBWF_CMD_MWI);
    post_case(0, 0, `PBWF_CMD_MWI, 32'h104, 8, 8, `PBWF_CMD_MW);
  endtask : t_posted
  // Far side stalls so a long burst fills the buffer
  task automatic t_full();
    int nx;
    pw_ready <= 1'b0;
    pw_q.delete();
    pwr(`PBWF_CMD_MW, 32'h200, 20, 4'h0, 32'h7700_0000, nx);
    chk("full_stop", nx >= 12 && nx <= 15, 1'b1);
    pw_ready <= 1'b1;
    repeat (30) @(posedge clk);
    chk("drained", pw_q.size(), nx + 1);
  endtask : t_full
  task automatic t_delayed(input logic [3:0] cmd, input logic [31:0] a);
    int nx, i0, t;
    logic [7:0] r0;
    cfg(`PBWF_OFS_RETRY_CNT, RST_RETRY, 1'b1);
    lat <= 4'hf;
    n_retry <= 8'h2;
    posted_clear <= 1'b0;
    i0 = issue_cnt;
    r0 = tries;
    pwr(cmd, a, 1, 4'h1, 32'h1234_5678, nx);
    chk("first_xfers", nx, 0);
    repeat (4) @(negedge clk);
    chk("held_back", tgt_req, 1'b0);
    @(posedge clk);
    posted_clear <= 1'b1;
    repeat (4) @(negedge clk);
    chk("tgt_cmd", tgt_cmd, cmd);
    chk("tgt_addr", tgt_addr, {a[31:2], 2'b00});
    chk("tgt_data", tgt_data, 32'h1234_5678);
    chk("tgt_be", tgt_be_n, 4'h1);
    pwr(cmd, a, 1, 4'h1, 32'h1234_5678, nx);
    chk("early_repeat", nx, 0);
    for (t = 0; t < 200 && tgt_req; t++) @(negedge clk);
    chk("one_issue", issue_cnt - i0, 1);
    chk("attempts", tries - r0, 2);
    pwr(cmd, a, 2, 4'h1, 32'h1234_56ff, nx);
    chk("repeat_xfers", nx, 1);
  endtask : t_delayed
  task automatic t_limit();
    int nx, s0, t;
    logic [7:0] r0;
    cfg(`PBWF_OFS_RETRY_CNT, 32'h8, 1'b1);
    never <= 1'b1;
    lat <= 4'h0;
    r0 = tries;
    s0 = serr_cnt;
    pwr(`PBWF_CMD_IOWR, 32'h3000, 1, 4'h0, 32'haa, nx);
    for (t = 0; t < 300 && serr_cnt == s0; t++) @(negedge clk);
    repeat (2) @(negedge clk);
    chk("limit_serr", serr_cnt - s0, 1);
    chk("limit_tries", tries - r0, 8);
    chk("limit_drop", tgt_req, 1'b0);
    never <= 1'b0;
  endtask : t_limit
  task automatic t_discard();
    int nx, s0;
    n_retry <= 8'h0;
    s0 = serr_cnt;
    pwr(`PBWF_CMD_IOWR, 32'h4000, 1, 4'h0, 32'h55, nx);
    repeat (30) @(posedge clk);
    chk("discard_serr", serr_cnt - s0, 1);
    cfg(`PBWF_OFS_RETRY_CNT, RST_RETRY, 1'b1);
    pwr(`PBWF_CMD_IOWR, 32'h4000, 1, 4'h0, 32'h55, nx);
    chk("after_drop", nx, 0);
    repeat (10) @(posedge clk);
    pwr(`PBWF_CMD_IOWR, 32'h4000, 1, 4'h0, 32'h55, nx);
    chk("timer_load", nx, 1);
  endtask : t_discard
  ////////////////////////////////////////
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_posted();
    t_full();
    t_delayed(`PBWF_CMD_IOWR, 32'h2000);
    t_delayed(`PBWF_CMD_CFGWR, 32'h1_0801);
    t_limit();
    t_discard();
    results();
  end
  // Run takes a few hundred cycles; the 20000-cycle limit leaves ample margin
  initial
  begin
    #(25 * 20000);
    error_cnt++;
    results();
  end
endmodule : pbwf_top_tb
bind pbwf_top pbwf_checker i_chk (.clk(clk), .rst_n(rst_n),
  .frame_n(frame_n), .cbe_n(cbe_n), .devsel_n(devsel_n), .trdy_n(trdy_n),
  .stop_n(stop_n), .tgt_oe_n(tgt_oe_n), .tgt_req(tgt_req),
  .tgt_cmd(tgt_cmd), .tgt_addr(tgt_addr), .tgt_data(tgt_data),
  .tgt_done(tgt_done), .serr_en(serr_en), .pw_valid(pw_valid),
  .pw_data(pw_data), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
  .cfg_wdata(cfg_wdata),
  .primary_system_error_out(primary_system_error_out));

// [hw/pbwf_defs.svh]
// Offsets, field positions, reset values and counts for the write path
// Assumes inclusion by design and bench files alike
`ifndef PBWF_DEFS_SVH
`define PBWF_DEFS_SVH
`define PBWF_OFS_CHIP_CTRL 8'h44
`define PBWF_OFS_WI_CTRL 8'h74
`define PBWF_OFS_RETRY_CNT 8'h88
`define PBWF_CC_MW_DISC 1
`define PBWF_WI_HI 8
`define PBWF_WI_LO 7
`define PBWF_CC_RESET 32'h0000_0000
`define PBWF_WI_RESET 32'h0000_0000
`define PBWF_CMD_IOWR 4'h3
`define PBWF_CMD_MW 4'h7
`define PBWF_CMD_CFGWR 4'hb
`define PBWF_CMD_MWI 4'hf
`define PBWF_PW_DEPTH 16
`define PBWF_PW_WIDTH 37
`define PBWF_DQ_DEPTH 4
`define PBWF_DQ_WIDTH 38
`define PBWF_HEAD_SETTLE 2'h2
`endif

// [hw/pbwf_dtq_mem.sv]
// Payload store of the delayed transaction queue
// Assumes the caller owns pointers; read data is registered
`timescale 1ns/1ps
module pbwf_dtq_mem #(
  parameter int W = 38,
  parameter int D = 4
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [$clog2(D)-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [$clog2(D)-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem_q [D];
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem_q[wr_addr] <= wr_data;
    rd_data <= mem_q[rd_addr];
  end
endmodule : pbwf_dtq_mem

// [hw/pbwf_fifo.sv]
// Posted write FIFO with a registered output stage
// Assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
module pbwf_fifo #(
  parameter int W = 37,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(D):0] count
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic ov_q;
  logic push;
  logic pop;
  // Output stage counts as one slot so full is honest
  assign in_ready = (cnt_q + {{AW{1'b0}}, ov_q}) < D[AW:0];
  assign push = in_valid && in_ready;
  assign pop = (cnt_q != '0) && (!ov_q || out_ready);
  assign out_valid = ov_q;
  assign count = cnt_q + {{AW{1'b0}}, ov_q};
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ov_q <= 1'b0;
      out_data <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
        out_data <= mem_q[rd_q];
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      if (pop)
        ov_q <= 1'b1;
      else if (out_ready)
        ov_q <= 1'b0;
    end
  end
endmodule : pbwf_fifo

// [hw/pbwf_pkg.sv]
// Types shared by the write-forwarding design files
// Assumes pbwf_defs.svh holds all numeric constants
package pbwf_pkg;
  typedef enum logic [2:0] {
    PBWF_IDLE = 3'b000,
    PBWF_DEC = 3'b001,
    PBWF_PDEV = 3'b010,
    PBWF_PDAT = 3'b011,
    PBWF_RETRY = 3'b100,
    PBWF_DWAIT = 3'b101,
    PBWF_DCMP = 3'b110,
    PBWF_TURN = 3'b111
  } pbwf_st_t;
endpackage : pbwf_pkg

// [hw/pbwf_top.sv]
// Write-forwarding core of a PCI-to-PCI bridge: target side, queues
// Assumes PCI signals are synchronous to clk; posted drain elsewhere
`timescale 1ns/1ps
`include "pbwf_defs.svh"
module pbwf_top #(
  parameter logic [31:0] RETRY_RESET = 32'h0100_0000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe_n,
  input wire logic par,
  input wire logic decode_hit,
  input wire logic upstream,
  input wire logic [7:0] cls,
  input wire logic serr_en,
  input wire logic fbb_up_en,
  input wire logic fbb_dn_en,
  input wire logic posted_clear,
  output logic devsel_n,
  output logic trdy_n,
  output logic stop_n,
  output logic tgt_oe_n,
  output logic tgt_req,
  output logic [3:0] tgt_cmd,
  output logic [31:0] tgt_addr,
  output logic [31:0] tgt_data,
  output logic [3:0] tgt_be_n,
  output logic tgt_par,
  input wire logic tgt_done,
  input wire logic tgt_retry,
  input wire logic tgt_err,
  output logic pw_valid,
  input wire logic pw_ready,
  output logic [36:0] pw_data,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic primary_system_error_out
);
  ////////////////////////////////////////////////////////////////////////
  // Declarations
  pbwf_pkg::pbwf_st_t st_q;
  logic [31:0] cc_q;
  logic [31:0] wi_q;
  logic [31:0] rty_q;
  logic frame_prev_q;
  logic [3:0] cmd_q;
  logic [29:0] addr_q;
  logic apar_q;
  logic posted_q;
  logic lin_q;
  logic enq_pend_q;
  logic [3:0] dv_q;
  logic [3:0] dd_q;
  logic [3:0] dcmd_q [4];
  logic [29:0] daddr_q [4];
  logic [1:0] hd_q;
  logic [1:0] tl_q;
  logic [2:0] dcnt_q;
  logic [1:0] age_q;
  logic [31:0] att_q;
  logic [31:0] disc_q;
  logic [37:0] head_pl;
  logic [4:0] pw_cnt;
  logic pw_in_ready;
  logic [4:0] pw_free;
  logic push;
  logic [36:0] push_data;
  logic addr_ph;
  logic is_posted;
  logic is_delayed;
  logic tag_hit_any;
  logic head_match;
  logic enq;
  logic deq_rep;
  logic deq;
  logic issue;
  logic lim_hit;
  logic disc_exp;
  logic line_mode;
  logic cls_ok;
  logic fbb_ok;

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic pbwf_last(input logic [29:0] a,
                                     input logic line,
                                     input logic [7:0] c);
    logic [7:0] m;
    m = c - 8'h01;
    if (line)
      pbwf_last = (a[7:0] & m) == m;
    else
      pbwf_last = a[9:0] == 10'h3ff;
  endfunction : pbwf_last

  function automatic logic pbwf_tag_eq(input logic [3:0] c1,
                                       input logic [29:0] a1,
                                       input logic [3:0] c2,
                                       input logic [29:0] a2);
    pbwf_tag_eq = (c1 == c2) && (a1 == a2);
  endfunction : pbwf_tag_eq

  ////////////////////////////////////////////////////////////////////////
  // Decode of the current bus request
  assign fbb_ok = upstream ? fbb_up_en : fbb_dn_en;
  assign addr_ph = !frame_n && frame_prev_q &&
                   ((st_q == pbwf_pkg::PBWF_IDLE) ||
                    ((st_q == pbwf_pkg::PBWF_TURN) && fbb_ok));
  assign is_posted = (~cbe_n == `PBWF_CMD_MW) ||
                     (~cbe_n == `PBWF_CMD_MWI);
  assign is_delayed = (~cbe_n == `PBWF_CMD_IOWR) ||
                      ((~cbe_n == `PBWF_CMD_CFGWR) &&
                       (ad[1:0] == 2'b01));
  assign cls_ok = (cls == 8'h01) || (cls == 8'h02) || (cls == 8'h04) ||
                  (cls == 8'h08) || (cls == 8'h10);
  assign pw_free = 5'(`PBWF_PW_DEPTH) - pw_cnt;
  always_comb
  begin
    line_mode = 1'b0;
    if (cmd_q == `PBWF_CMD_MW)
      line_mode = cc_q[`PBWF_CC_MW_DISC] && cls_ok;
    else if (wi_q[`PBWF_WI_HI:`PBWF_WI_LO] == 2'b11)
      line_mode = cls_ok;
    else
      line_mode = cls_ok && ({3'b000, pw_free} < cls);
  end

  always_comb
  begin
    tag_hit_any = 1'b0;
    for (int i = 0; i < `PBWF_DQ_DEPTH; i++)
      if (dv_q[i] && pbwf_tag_eq(dcmd_q[i], daddr_q[i], cmd_q, addr_q))
        tag_hit_any = 1'b1;
  end

  // Only enabled bytes take part in the compare
  always_comb
  begin
    head_match = (head_pl[35:32] == cbe_n);
    for (int b = 0; b < 4; b++)
      if (!cbe_n[b] && (head_pl[8*b +: 8] != ad[8*b +: 8]))
        head_match = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Target-side state machine toward the initiator
  assign push = ((st_q == pbwf_pkg::PBWF_DEC) && posted_q &&
                 (pw_free >= 5'h02)) ||
                ((st_q == pbwf_pkg::PBWF_PDAT) && !irdy_n);
  always_comb
  begin
    push_data = {1'b0, cbe_n, ad};
    if (st_q == pbwf_pkg::PBWF_DEC)
    begin
      push_data = {1'b1, cmd_q, addr_q, 2'b00};
      if ((cmd_q == `PBWF_CMD_MWI) &&
          (wi_q[`PBWF_WI_HI:`PBWF_WI_LO] == 2'b00))
        push_data[35:32] = `PBWF_CMD_MW;
    end
  end
  assign enq = (st_q == pbwf_pkg::PBWF_RETRY) && enq_pend_q && !irdy_n &&
               !tag_hit_any && (dcnt_q < 3'(`PBWF_DQ_DEPTH));
  assign deq_rep = (st_q == pbwf_pkg::PBWF_DWAIT) && !irdy_n &&
                   head_match;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      frame_prev_q <= 1'b1;
    else
      frame_prev_q <= frame_n;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q <= pbwf_pkg::PBWF_IDLE;
      devsel_n <= 1'b1;
      trdy_n <= 1'b1;
      stop_n <= 1'b1;
      tgt_oe_n <= 1'b1;
      cmd_q <= 4'h0;
      addr_q <= 30'h0;
      apar_q <= 1'b0;
      posted_q <= 1'b0;
      lin_q <= 1'b1;
      enq_pend_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        pbwf_pkg::PBWF_IDLE, pbwf_pkg::PBWF_TURN:
        begin
          tgt_oe_n <= 1'b1;
          st_q <= pbwf_pkg::PBWF_IDLE;
          if (addr_ph && decode_hit && (is_posted || is_delayed))
          begin
            cmd_q <= ~cbe_n;
            addr_q <= ad[31:2];
            apar_q <= par;
            lin_q <= ad[1:0] == 2'b00;
            posted_q <= is_posted;
            st_q <= pbwf_pkg::PBWF_DEC;
          end
        end
        pbwf_pkg::PBWF_DEC:
        begin
          devsel_n <= 1'b0;
          tgt_oe_n <= 1'b0;
          enq_pend_q <= 1'b0;
          if (posted_q)
          begin
            if (pw_free >= 5'h02)
              st_q <= pbwf_pkg::PBWF_PDEV;
            else
            begin
              stop_n <= 1'b0;
              st_q <= pbwf_pkg::PBWF_RETRY;
            end
          end
          else if (dv_q[hd_q] && dd_q[hd_q] &&
                   pbwf_tag_eq(dcmd_q[hd_q], daddr_q[hd_q], cmd_q, addr_q))
            st_q <= pbwf_pkg::PBWF_DWAIT;
          else
          begin
            stop_n <= 1'b0;
            enq_pend_q <= !tag_hit_any;
            st_q <= pbwf_pkg::PBWF_RETRY;
          end
        end
        pbwf_pkg::PBWF_PDEV:
        begin
          trdy_n <= 1'b0;
          stop_n <= !(pbwf_last(addr_q, line_mode, cls) || !lin_q);
          st_q <= pbwf_pkg::PBWF_PDAT;
        end
        pbwf_pkg::PBWF_PDAT:
        begin
          if (!irdy_n)
          begin
            addr_q <= addr_q + 30'h1;
            if (frame_n || !stop_n)
            begin
              devsel_n <= 1'b1;
              trdy_n <= 1'b1;
              stop_n <= 1'b1;
              st_q <= pbwf_pkg::PBWF_TURN;
            end
            else
              stop_n <= !(pbwf_last(addr_q + 30'h1, line_mode, cls) ||
                          (pw_free <= 5'h02));
          end
        end
        pbwf_pkg::PBWF_RETRY:
        begin
          if (!irdy_n)
          begin
            devsel_n <= 1'b1;
            stop_n <= 1'b1;
            enq_pend_q <= 1'b0;
            st_q <= pbwf_pkg::PBWF_TURN;
          end
        end
        pbwf_pkg::PBWF_DWAIT:
        begin
          if (!irdy_n)
          begin
            if (head_match)
            begin
              trdy_n <= 1'b0;
              stop_n <= frame_n;
              st_q <= pbwf_pkg::PBWF_DCMP;
            end
            else
            begin
              stop_n <= 1'b0;
              st_q <= pbwf_pkg::PBWF_RETRY;
            end
          end
        end
        pbwf_pkg::PBWF_DCMP:
        begin
          devsel_n <= 1'b1;
          trdy_n <= 1'b1;
          stop_n <= 1'b1;
          st_q <= pbwf_pkg::PBWF_TURN;
        end
        default:
          st_q <= pbwf_pkg::PBWF_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Delayed transaction queue tags and pointers
  assign deq = deq_rep || disc_exp || lim_hit || (tgt_req && tgt_err);
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dv_q <= 4'h0;
      dd_q <= 4'h0;
      hd_q <= 2'h0;
      tl_q <= 2'h0;
      dcnt_q <= 3'h0;
      for (int i = 0; i < `PBWF_DQ_DEPTH; i++)
      begin
        dcmd_q[i] <= 4'h0;
        daddr_q[i] <= 30'h0;
      end
    end
    else
    begin
      if (enq)
      begin
        dv_q[tl_q] <= 1'b1;
        dd_q[tl_q] <= 1'b0;
        dcmd_q[tl_q] <= cmd_q;
        daddr_q[tl_q] <= addr_q;
        tl_q <= tl_q + 2'h1;
      end
      if (tgt_req && tgt_done)
        dd_q[hd_q] <= 1'b1;
      if (deq)
      begin
        dv_q[hd_q] <= 1'b0;
        hd_q <= hd_q + 2'h1;
      end
      dcnt_q <= dcnt_q + {2'b00, enq} - {2'b00, deq};
    end
  end

  pbwf_dtq_mem #(
    .W(`PBWF_DQ_WIDTH),
    .D(`PBWF_DQ_DEPTH)
  ) u_dtq_mem (
    .clk(clk),
    .wr_en(enq),
    .wr_addr(tl_q),
    .wr_data({apar_q, par, cbe_n, ad}),
    .rd_addr(hd_q),
    .rd_data(head_pl)
  );

  ////////////////////////////////////////////////////////////////////////
  // Delivery on the target bus, attempts and discard timer
  // Registered payload lags a head change, so issue waits for it
  assign issue = dv_q[hd_q] && !dd_q[hd_q] && !tgt_req && posted_clear &&
                 (age_q == `PBWF_HEAD_SETTLE) && !deq;
  // Limit of zero wraps the counter, which gives the 2^32 maximum
  assign lim_hit = tgt_req && tgt_retry && (att_q == rty_q);
  assign disc_exp = dv_q[hd_q] && dd_q[hd_q] && !deq_rep &&
                    (disc_q == 32'h1);

  always_ff @(posedge clk)
  begin
    if (!rst_n || deq || !dv_q[hd_q])
      age_q <= 2'h0;
    else if (age_q != `PBWF_HEAD_SETTLE)
      age_q <= age_q + 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tgt_req <= 1'b0;
      tgt_cmd <= 4'h0;
      tgt_addr <= 32'h0;
      tgt_data <= 32'h0;
      tgt_be_n <= 4'hf;
      tgt_par <= 1'b0;
      att_q <= 32'h0;
    end
    else
    begin
      if (issue)
      begin
        tgt_req <= 1'b1;
        tgt_cmd <= dcmd_q[hd_q];
        tgt_addr <= {daddr_q[hd_q], 2'b00};
        tgt_data <= head_pl[31:0];
        tgt_be_n <= head_pl[35:32];
        tgt_par <= head_pl[36];
        att_q <= 32'h1;
      end
      else if (tgt_req && tgt_retry && !lim_hit)
        att_q <= att_q + 32'h1;
      else if (tgt_req && (tgt_done || tgt_err || lim_hit))
        tgt_req <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      disc_q <= 32'h0;
    else if (tgt_req && tgt_done)
      disc_q <= rty_q;
    else if (dv_q[hd_q] && dd_q[hd_q])
      disc_q <= disc_q - 32'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      primary_system_error_out <= 1'b0;
    else
      primary_system_error_out <= serr_en && (lim_hit || disc_exp);
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cc_q <= `PBWF_CC_RESET;
      wi_q <= `PBWF_WI_RESET;
      rty_q <= RETRY_RESET;
    end
    else if (cfg_wr)
    begin
      if (cfg_addr == `PBWF_OFS_CHIP_CTRL)
        cc_q <= cfg_wdata;
      if (cfg_addr == `PBWF_OFS_WI_CTRL)
        wi_q <= cfg_wdata;
      if (cfg_addr == `PBWF_OFS_RETRY_CNT)
        rty_q <= cfg_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cfg_rdata <= 32'h0;
    else
      case (cfg_addr)
        `PBWF_OFS_CHIP_CTRL: cfg_rdata <= cc_q;
        `PBWF_OFS_WI_CTRL: cfg_rdata <= wi_q;
        `PBWF_OFS_RETRY_CNT: cfg_rdata <= rty_q;
        default: cfg_rdata <= 32'h0;
      endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Posted write buffer
  pbwf_fifo #(
    .W(`PBWF_PW_WIDTH),
    .D(`PBWF_PW_DEPTH)
  ) u_pw_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(pw_in_ready),
    .in_data(push_data),
    .out_valid(pw_valid),
    .out_ready(pw_ready),
    .out_data(pw_data),
    .count(pw_cnt)
  );
  // Admission checks pw_free instead
endmodule : pbwf_top
